// *** core/sdck_pkg.sv ***
// Purpose: Shared constants and types for the command-side state logic
// Assumes: Command pins come from logic on the same clock
// Notes:   All timing counts are in clock cycles of mclk_i
package sdck_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int BANK_W  = 3;
	localparam int NBANK   = 8;
	localparam int ROW_W   = 16;
	localparam int COL_W   = 10;
	localparam int CODE_W  = 6;
	localparam int CNT_W   = 10;

	// ------------------------------------------------------------
	// Address field positions
	// ------------------------------------------------------------
	localparam int A_AP    = 10;
	localparam int A_BC    = 12;
	localparam int A_COL_L = 3;
	localparam int A_COL_H = 9;

	// ------------------------------------------------------------
	// Timing counts
	// ------------------------------------------------------------
	localparam logic [CNT_W-1:0] ZQINIT_CYC = 10'h200;
	localparam logic [CNT_W-1:0] ZQOPER_CYC = 10'h100;
	localparam logic [CNT_W-1:0] ZQCS_CYC   = 10'h040;
	localparam logic [CNT_W-1:0] RFC_CYC    = 10'h040;
	localparam logic [2:0]       LAST_BL8   = 3'h7;
	localparam logic [2:0]       LAST_BC4   = 3'h3;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_ACTIVE = 5'h02,
		ST_PD_PRE = 5'h04,
		ST_PD_ACT = 5'h08,
		ST_SELF   = 5'h10
	} sdck_state_t;

	typedef enum logic [3:0] {
		CMD_DES  = 4'h0,
		CMD_NOP  = 4'h1,
		CMD_MRS  = 4'h2,
		CMD_REF  = 4'h3,
		CMD_PRE  = 4'h4,
		CMD_PREA = 4'h5,
		CMD_ACT  = 4'h6,
		CMD_WR   = 4'h7,
		CMD_RD   = 4'h8,
		CMD_ZQCL = 4'h9,
		CMD_ZQCS = 4'ha
	} sdck_cmd_t;

endpackage : sdck_pkg

// *** core/sdck_row_mem.sv ***
// Purpose: Open-row store, one row number per bank
// Assumes: One write port, one read port, same clock
// Notes:   Read data is registered, valid one cycle after raddr_i
`timescale 1ns/1ps
module sdck_row_mem (
	// Clock and reset
	input  wire logic                          mclk_i,
	input  wire logic                          resetn_i,
	// Write side
	input  wire logic                          we_i,
	input  wire logic [sdck_pkg::BANK_W-1:0]   waddr_i,
	input  wire logic [sdck_pkg::ROW_W-1:0]    wdata_i,
	// Read side
	input  wire logic [sdck_pkg::BANK_W-1:0]   raddr_i,
	output logic      [sdck_pkg::ROW_W-1:0]    rdata_o
);
	import sdck_pkg::*;

	logic [ROW_W-1:0] mem [NBANK];

	always_ff @(posedge mclk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	// Write-through so a read of the bank written on the same edge sees the new row
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= '0;
		end else if (we_i && waddr_i == raddr_i) begin
			rdata_o <= wdata_i;
		end else begin
			rdata_o <= mem[raddr_i];
		end
	end

endmodule : sdck_row_mem

// *** core/sdck_cmd.sv ***
// Purpose: Clock-enable power states, command decode, ZQ and READ handling
// Assumes: Controller logic shares mclk_i; pins sampled on each rising edge
// Notes:   WRITE data path, mode registers and analog timing are outside
//
// Contract
// - Unlisted state, clock-enable and command combinations are illegal; never issued.
// - Low-low clock enable keeps power-down or self refresh; rise with DES/NOP exits.
// - Falling enable with DES/NOP while busy or active enters power-down.
// - Falling enable when idle: DES/NOP gives precharge power-down, REFRESH self refresh.
// - Transition-edge command must be legal; termination input never affects power state.
// - Chip select high ignores other pins; running work continues.
// - NOP registers no command and lets running work finish.
// - Long calibration runs the engine, then loads driver and termination codes.
// - Short calibration does a reduced recalibration; controller waits its window.
// - Short calibration completes its correction within 64 clock cycles.
// - ACTIVATE opens the row on the address pins in the addressed bank.
// - An opened row stays available until that bank is precharged.
// - READ low address bits set start column; order follows length and type.
// - Address bit 10 at READ selects auto precharge when high.
// - Auto precharge closes the row after the burst; otherwise it stays open.
// - With on-the-fly enabled, bit 12 low chops to four beats, high gives eight.
// - An accepted READ burst runs to completion and cannot be cut short.
// - READ decodes as select low, row high, column low, write-enable high.
// - Commands decode from select, strobes and clock enable on the rising edge.
// - Power-down does no refresh of its own; controller keeps scheduling it.
`timescale 1ns/1ps
module sdck_cmd (
	// Clock and reset
	input  wire logic                          mclk_i,
	input  wire logic                          resetn_i,
	// Command pins
	input  wire logic                          cke_i,
	input  wire logic                          cs_n_i,
	input  wire logic                          ras_n_i,
	input  wire logic                          cas_n_i,
	input  wire logic                          we_n_i,
	input  wire logic [sdck_pkg::BANK_W-1:0]   ba_i,
	input  wire logic [sdck_pkg::ROW_W-1:0]    addr_i,
	// Configuration
	input  wire logic                          otf_en_i,
	input  wire logic                          fixed_bc4_i,
	input  wire logic                          interleave_i,
	input  wire logic                          init_done_i,
	input  wire logic [2*sdck_pkg::CODE_W-1:0] cal_code_i,
	// Power and bank status
	output logic      [4:0]                    pstate_o,
	output logic                               pd_o,
	output logic                               self_ref_o,
	output logic      [sdck_pkg::NBANK-1:0]    bank_open_o,
	output logic                               refreshing_o,
	output logic                               illegal_o,
	// Read burst
	output logic                               rd_busy_o,
	output logic      [sdck_pkg::BANK_W-1:0]   rd_bank_o,
	output logic      [sdck_pkg::ROW_W-1:0]    rd_row_o,
	output logic      [sdck_pkg::COL_W-1:0]    rd_col_o,
	output logic                               rd_chop_o,
	output logic                               rd_ap_o,
	// Calibration
	output logic                               cal_busy_o,
	output logic                               cal_long_o,
	output logic                               cal_update_o,
	output logic      [sdck_pkg::CODE_W-1:0]   ron_code_o,
	output logic      [sdck_pkg::CODE_W-1:0]   odt_code_o
);
	import sdck_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		sdck_state_t      state;
		logic             cke_prev;
		logic [NBANK-1:0] open;
		logic             rd_busy;
		logic [2:0]       rd_beat;
		logic [2:0]       rd_start;
		logic [6:0]       rd_col_hi;
		logic [2:0]       rd_col;
		logic [BANK_W-1:0] rd_bank;
		logic             rd_chop;
		logic             rd_ap;
		logic             rd_inter;
		logic             cal_busy;
		logic             cal_long;
		logic [CNT_W-1:0] cal_cnt;
		logic             cal_upd;
		logic [CODE_W-1:0] ron;
		logic [CODE_W-1:0] odt;
		logic [CNT_W-1:0] ref_cnt;
		logic             illegal;
		logic             rd_take;
		logic [ROW_W-1:0] rd_row;
	} sdck_regs_t;

	sdck_regs_t r;
	sdck_regs_t next_r;

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic sdck_cmd_t cmd_decode(input logic cs_n, input logic ras_n,
		input logic cas_n, input logic we_n, input logic a10);
		logic [2:0] s;
		s = {ras_n, cas_n, we_n};
		if (cs_n) begin
			cmd_decode = CMD_DES;
		end else begin
			case (s)
				3'h0:    cmd_decode = CMD_MRS;
				3'h1:    cmd_decode = CMD_REF;
				3'h2:    cmd_decode = a10 ? CMD_PREA : CMD_PRE;
				3'h3:    cmd_decode = CMD_ACT;
				3'h4:    cmd_decode = CMD_WR;
				3'h5:    cmd_decode = CMD_RD;
				3'h6:    cmd_decode = a10 ? CMD_ZQCL : CMD_ZQCS;
				default: cmd_decode = CMD_NOP;
			endcase
		end
	endfunction : cmd_decode

	// Sequential order wraps inside the nibble, interleaved is an XOR
	function automatic logic [2:0] burst_col(input logic [2:0] start, input logic [2:0] beat,
		input logic inter, input logic chop);
		logic [1:0] lo;
		lo = start[1:0] + beat[1:0];
		if (inter) begin
			burst_col = start ^ beat;
		end else if (chop) begin
			burst_col = {start[2], lo};
		end else begin
			burst_col = {start[2] ^ beat[2], lo};
		end
	endfunction : burst_col

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	sdck_cmd_t cmd;
	logic      desnop;
	logic      awake;
	logic      quiet;
	logic      rd_last;
	logic      new_chop;
	logic      act_we;
	logic [ROW_W-1:0] row_q;

	// Termination input deliberately not a port: it never steers power state
	always_comb begin
		cmd      = cmd_decode(cs_n_i, ras_n_i, cas_n_i, we_n_i, addr_i[A_AP]);
		desnop   = (cmd == CMD_DES) || (cmd == CMD_NOP);
		awake    = (r.state == ST_IDLE) || (r.state == ST_ACTIVE);
		quiet    = !r.rd_busy && !r.cal_busy && (r.ref_cnt == '0);
		rd_last  = r.rd_busy && (r.rd_beat == (r.rd_chop ? LAST_BC4 : LAST_BL8));
		new_chop = otf_en_i ? !addr_i[A_BC] : fixed_bc4_i;
		act_we   = awake && r.cke_prev && cke_i && (cmd == CMD_ACT)
			&& !r.open[ba_i] && r.ref_cnt == '0;
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_r          = r;
		next_r.cke_prev = cke_i;
		next_r.illegal  = 1'b0;
		next_r.cal_upd  = 1'b0;

		// Running work advances whatever the command, even in power-down
		if (r.rd_busy) begin
			next_r.rd_beat = r.rd_beat + 3'h1;
			next_r.rd_col  = burst_col(r.rd_start, r.rd_beat + 3'h1, r.rd_inter, r.rd_chop);
			if (rd_last) begin
				next_r.rd_busy = 1'b0;
				if (r.rd_ap) begin
					next_r.open[r.rd_bank] = 1'b0;
				end
			end
		end
		if (r.ref_cnt != '0) begin
			next_r.ref_cnt = r.ref_cnt - 10'h001;
		end
		if (r.cal_busy) begin
			if (r.cal_cnt == 10'h001) begin
				next_r.cal_busy = 1'b0;
				next_r.cal_upd  = 1'b1;
				next_r.ron      = cal_code_i[CODE_W-1:0];
				next_r.odt      = cal_code_i[2*CODE_W-1:CODE_W];
			end
			next_r.cal_cnt = r.cal_cnt - 10'h001;
		end

		case (r.state)
			ST_PD_PRE, ST_PD_ACT, ST_SELF: begin
				if (r.cke_prev && cke_i) begin
					next_r.illegal = 1'b1;
				end else if (!r.cke_prev && cke_i) begin
					if (desnop) begin
						next_r.state = (r.state == ST_PD_ACT) ? ST_ACTIVE : ST_IDLE;
					end else begin
						next_r.illegal = 1'b1;
					end
				end
				// Low-low keeps the state, no refresh is started here
			end
			ST_IDLE, ST_ACTIVE: begin
				if (r.cke_prev && !cke_i) begin
					if (desnop) begin
						if (r.open != '0 || r.rd_busy) begin
							next_r.state = ST_PD_ACT;
						end else begin
							next_r.state = ST_PD_PRE;
						end
					end else if (cmd == CMD_REF && r.open == '0 && quiet) begin
						next_r.state = ST_SELF;
					end else begin
						next_r.illegal = 1'b1;
					end
				end else if (r.cke_prev && cke_i) begin
					case (cmd)
						CMD_DES, CMD_NOP: begin
						end
						CMD_ACT: begin
							if (act_we) begin
								next_r.open[ba_i] = 1'b1;
							end else begin
								next_r.illegal = 1'b1;
							end
						end
						CMD_PRE: begin
							if (!(r.rd_busy && r.rd_bank == ba_i)) begin
								next_r.open[ba_i] = 1'b0;
							end else begin
								next_r.illegal = 1'b1;
							end
						end
						CMD_PREA: begin
							if (!r.rd_busy) begin
								next_r.open = '0;
							end else begin
								next_r.illegal = 1'b1;
							end
						end
						CMD_REF: begin
							if (r.open == '0 && quiet) begin
								next_r.ref_cnt = RFC_CYC;
							end else begin
								next_r.illegal = 1'b1;
							end
						end
						CMD_ZQCL, CMD_ZQCS: begin
							if (r.open == '0 && quiet) begin
								next_r.cal_busy = 1'b1;
								next_r.cal_long = (cmd == CMD_ZQCL);
								if (cmd == CMD_ZQCS) begin
									next_r.cal_cnt = ZQCS_CYC;
								end else if (init_done_i) begin
									next_r.cal_cnt = ZQOPER_CYC;
								end else begin
									next_r.cal_cnt = ZQINIT_CYC;
								end
							end else begin
								next_r.illegal = 1'b1;
							end
						end
						CMD_RD: begin
							if (r.open[ba_i] && !r.rd_busy) begin
								next_r.rd_busy   = 1'b1;
								next_r.rd_beat   = 3'h0;
								next_r.rd_bank   = ba_i;
								next_r.rd_start  = addr_i[2:0];
								next_r.rd_col    = addr_i[2:0];
								next_r.rd_col_hi = addr_i[A_COL_H:A_COL_L];
								next_r.rd_ap     = addr_i[A_AP];
								next_r.rd_chop   = new_chop;
								next_r.rd_inter  = interleave_i;
							end else begin
								next_r.illegal = 1'b1;
							end
						end
						default: begin
							// Mode set and write are accepted without effect here
						end
					endcase
				end
				if (next_r.state == ST_IDLE || next_r.state == ST_ACTIVE) begin
					next_r.state = (next_r.open != '0) ? ST_ACTIVE : ST_IDLE;
				end
			end
			default: begin
				next_r.state = ST_IDLE;
			end
		endcase

		// Row of the accepted READ, caught from the store one cycle later
		next_r.rd_take = !r.rd_busy && next_r.rd_busy;
		next_r.rd_row  = r.rd_take ? row_q : r.rd_row;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			r          <= '0;
			r.state    <= ST_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------
	// Row store
	// ------------------------------------------------------------
	sdck_row_mem u_row_mem (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.we_i     (act_we),
		.waddr_i  (ba_i),
		.wdata_i  (addr_i),
		.raddr_i  (ba_i),
		.rdata_o  (row_q)
	);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always_comb begin
		pstate_o     = r.state;
		pd_o         = (r.state == ST_PD_PRE) || (r.state == ST_PD_ACT);
		self_ref_o   = (r.state == ST_SELF);
		bank_open_o  = r.open;
		refreshing_o = (r.ref_cnt != '0);
		illegal_o    = r.illegal;
		rd_busy_o    = r.rd_busy;
		rd_bank_o    = r.rd_bank;
		rd_row_o     = r.rd_take ? row_q : r.rd_row;
		rd_col_o     = {r.rd_col_hi, r.rd_col};
		rd_chop_o    = r.rd_chop;
		rd_ap_o      = r.rd_ap;
		cal_busy_o   = r.cal_busy;
		cal_long_o   = r.cal_long;
		cal_update_o = r.cal_upd;
		ron_code_o   = r.ron;
		odt_code_o   = r.odt;
	end

endmodule : sdck_cmd

// *** sim/sdck_cmd_props.sv ***
// Purpose: Port-level checks on the command state logic
// Assumes: One clock, asynchronous active-low reset
// Notes:   Keeps its own previous clock-enable level, reset low like the design's
`timescale 1ns/1ps
module sdck_cmd_props (
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	// Command pins
	input  wire logic        cke_i,
	input  wire logic        cs_n_i,
	input  wire logic        ras_n_i,
	input  wire logic        cas_n_i,
	input  wire logic        we_n_i,
	input  wire logic [2:0]  ba_i,
	input  wire logic [15:0] addr_i,
	// Configuration
	input  wire logic        otf_en_i,
	input  wire logic [11:0] cal_code_i,
	// Power and bank status
	input  wire logic [4:0]  pstate_o,
	input  wire logic        pd_o,
	input  wire logic        self_ref_o,
	input  wire logic        refreshing_o,
	input  wire logic        illegal_o,
	input  wire logic [7:0]  bank_open_o,
	// Read burst
	input  wire logic        rd_busy_o,
	input  wire logic        rd_ap_o,
	input  wire logic [2:0]  rd_bank_o,
	input  wire logic [9:0]  rd_col_o,
	// Calibration
	input  wire logic        cal_busy_o,
	input  wire logic        cal_update_o,
	input  wire logic [5:0]  ron_code_o,
	input  wire logic [5:0]  odt_code_o
);
	logic cke_q, hh, dn, cl, quiet, rd, act, zqs, sre, pde, slp;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) cke_q <= 1'b0;
		else cke_q <= cke_i;
	end

	assign hh    = cke_q & cke_i;
	assign dn    = cs_n_i | (ras_n_i & cas_n_i & we_n_i);
	assign cl    = hh & !cs_n_i;
	assign slp   = pd_o | self_ref_o;
	assign quiet = !rd_busy_o & !cal_busy_o & !refreshing_o & (bank_open_o == 8'h00)
		& (pstate_o == 5'h01);
	assign rd    = cl & ras_n_i & !cas_n_i & we_n_i & !rd_busy_o & bank_open_o[ba_i]
		& (pstate_o == 5'h02);
	assign act   = cl & !ras_n_i & cas_n_i & we_n_i & !bank_open_o[ba_i] & !refreshing_o
		& (pstate_o[0] | pstate_o[1]);
	assign zqs   = cl & ras_n_i & cas_n_i & !we_n_i & !addr_i[10] & quiet;
	assign sre   = cke_q & !cke_i & !cs_n_i & !ras_n_i & !cas_n_i & we_n_i & quiet;
	assign pde   = cke_q & !cke_i & dn & (pstate_o[0] | pstate_o[1]);

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	property p_pd_in;
		pde |=> pd_o;
	endproperty
	a_pd_in: assert property (p_pd_in) else $error("power-down entry missed");
	property p_sr_in;
		sre |=> self_ref_o && pstate_o == 5'h10;
	endproperty
	a_sr_in: assert property (p_sr_in) else $error("self refresh entry missed");
	property p_sleep_hold;
		slp && !cke_q && !cke_i |=> $stable(pstate_o);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("sleep state left");
	property p_sleep_exit;
		slp && !cke_q && cke_i && dn |=> !pd_o && !self_ref_o && (pstate_o[0] || pstate_o[1]);
	endproperty
	a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit missed");
	property p_quiet_cmd;
		hh && dn && !slp && !rd_busy_o |=> $stable(bank_open_o) && $stable(pstate_o) && !illegal_o;
	endproperty
	a_quiet_cmd: assert property (p_quiet_cmd) else $error("idle command had effect");
	property p_act;
		act |=> bank_open_o[$past(ba_i)];
	endproperty
	a_act: assert property (p_act) else $error("activate did not open bank");
	property p_rd_start;
		rd |=> rd_busy_o && rd_bank_o == $past(ba_i) && rd_col_o == $past(addr_i[9:0])
			&& rd_ap_o == $past(addr_i[10]);
	endproperty
	a_rd_start: assert property (p_rd_start) else $error("read start fields wrong");
	property p_rd_bc4;
		rd && otf_en_i && !addr_i[12] |=> rd_busy_o [*4] ##1 !rd_busy_o;
	endproperty
	a_rd_bc4: assert property (p_rd_bc4) else $error("chopped burst length wrong");
	property p_rd_bl8;
		rd && otf_en_i && addr_i[12] |=> rd_busy_o [*8] ##1 !rd_busy_o;
	endproperty
	a_rd_bl8: assert property (p_rd_bl8) else $error("full burst length wrong");
	property p_zqcs;
		zqs |=> cal_busy_o ##63 cal_busy_o ##1 (!cal_busy_o && cal_update_o);
	endproperty
	a_zqcs: assert property (p_zqcs) else $error("short calibration window wrong");
	property p_cal_load;
		cal_update_o |-> ron_code_o == $past(cal_code_i[5:0])
			&& odt_code_o == $past(cal_code_i[11:6]);
	endproperty
	a_cal_load: assert property (p_cal_load) else $error("calibration codes not loaded");
endmodule : sdck_cmd_props

// *** sim/sdck_ctl_model.sv ***
// Purpose: Behavioural controller driving the command pins
// Assumes: One command per cycle, launched on the falling edge
// Notes:   Deselected pins are flipped, never left at the last value
`timescale 1ns/1ps
module sdck_ctl_model
	import sdck_pkg::*;
(
	// Clock
	input  wire logic        mclk_i,
	// Command pins
	output logic             cke_o,
	output logic             cs_n_o,
	output logic             ras_n_o,
	output logic             cas_n_o,
	output logic             we_n_o,
	output logic [2:0]       ba_o,
	output logic [15:0]      addr_o
);
	initial begin
		cke_o = 1'b0;
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h7;
		ba_o = 3'h0;
		addr_o = 16'h0000;
	end

	task automatic issue(input sdck_cmd_t c, input logic k, input logic [2:0] b,
		input logic [15:0] a);
		logic [2:0] s;
		@(negedge mclk_i);
		case (c)
			CMD_MRS:            s = 3'h0;
			CMD_REF:            s = 3'h1;
			CMD_PRE, CMD_PREA:  s = 3'h2;
			CMD_ACT:            s = 3'h3;
			CMD_WR:             s = 3'h4;
			CMD_RD:             s = 3'h5;
			CMD_ZQCL, CMD_ZQCS: s = 3'h6;
			default:            s = 3'h7;
		endcase
		cke_o = k;
		cs_n_o = (c == CMD_DES);
		if (c == CMD_DES) begin
			{ras_n_o, cas_n_o, we_n_o} = ~{ras_n_o, cas_n_o, we_n_o};
			ba_o = ~ba_o;
			addr_o = ~addr_o;
		end else begin
			{ras_n_o, cas_n_o, we_n_o} = s;
			ba_o = b;
			addr_o = a;
		end
	endtask : issue
endmodule : sdck_ctl_model

// *** sim/sdck_cmd_tb_top.sv ***
// Purpose: Directed bench for the command state logic
// Assumes: Controller model launches commands on falling edges
// Notes:   Fixed waits follow the documented latencies
`timescale 1ns/1ps
module sdck_cmd_tb_top;
	import sdck_pkg::*;
	logic mclk_i = 1'b0, resetn_i = 1'b0, otf_en_i = 1'b0, fixed_bc4_i = 1'b0;
	logic interleave_i = 1'b0, init_done_i = 1'b0, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i;
	logic [11:0] cal_code_i = 12'h000;
	logic [2:0]  ba_i, rd_bank_o;
	logic [15:0] addr_i, rd_row_o;
	logic [4:0]  pstate_o;
	logic [7:0]  bank_open_o;
	logic [9:0]  rd_col_o;
	logic [5:0]  ron_code_o, odt_code_o;
	logic pd_o, self_ref_o, refreshing_o, illegal_o, rd_busy_o, rd_chop_o, rd_ap_o;
	logic cal_busy_o, cal_long_o, cal_update_o, ap, a12, ch;
	int n_mismatch = 0;
	int checks = 0;
	int len;

	always #2.5 mclk_i = ~mclk_i;

	sdck_ctl_model u_ctl (.mclk_i, .cke_o(cke_i), .cs_n_o(cs_n_i), .ras_n_o(ras_n_i),
		.cas_n_o(cas_n_i), .we_n_o(we_n_i), .ba_o(ba_i), .addr_o(addr_i));
	sdck_cmd u_dut (.mclk_i, .resetn_i, .cke_i, .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i, .ba_i,
		.addr_i, .otf_en_i, .fixed_bc4_i, .interleave_i, .init_done_i, .cal_code_i, .pstate_o,
		.pd_o, .self_ref_o, .bank_open_o, .refreshing_o, .illegal_o, .rd_busy_o, .rd_bank_o,
		.rd_row_o, .rd_col_o, .rd_chop_o, .rd_ap_o, .cal_busy_o, .cal_long_o, .cal_update_o,
		.ron_code_o, .odt_code_o);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic tally_and_finish();
		if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	task automatic go(input sdck_cmd_t c, input logic k = 1'b1, input logic [2:0] b = 3'h3,
		input logic [15:0] a = 16'h0000);
		u_ctl.issue(c, k, b, a);
	endtask : go

	task automatic nops(input int n);
		repeat (n) go(CMD_NOP);
	endtask : nops

	// Burst column order for one beat
	function automatic logic [9:0] col_at(input logic [9:0] s, input int b, input logic il,
		input logic c);
		logic [2:0] o;
		if (il) o = s[2:0] ^ b[2:0];
		else if (c) o = {s[2], s[1:0] + b[1:0]};
		else o = {s[2] ^ b[2], s[1:0] + b[1:0]};
		return {s[9:3], o};
	endfunction : col_at

	initial begin
		repeat (12) @(posedge mclk_i);
		@(negedge mclk_i) resetn_i = 1'b1;
		check("pstate", pstate_o, 32'h01);
		nops(2);
		// Long calibration in and after init, then short
		for (int j = 0; j < 3; j++) begin
			init_done_i = (j != 0);
			cal_code_i = 12'h5a3 ^ j;
			len = (j == 0) ? 512 : (j == 1) ? 256 : 64;
			go((j < 2) ? CMD_ZQCL : CMD_ZQCS, 1'b1, 3'h0, (j < 2) ? 16'h0400 : 16'h0000);
			nops(len);
			check("cal_busy", cal_busy_o, 32'h1);
			nops(1);
			check("cal_busy", cal_busy_o, 32'h0);
			check("cal_update", cal_update_o, 32'h1);
			check("ron", ron_code_o, cal_code_i[5:0]);
			check("odt", odt_code_o, cal_code_i[11:6]);
			check("cal_long", cal_long_o, j < 2);
		end
		go(CMD_ACT, 1'b1, 3'h3, 16'h1234);
		go(CMD_REF);
		check("banks", bank_open_o, 32'h08);
		go(CMD_NOP);
		check("illegal", illegal_o, 32'h1);
		// Read variants, a second read thrown in mid-burst
		for (int j = 0; j < 5; j++) begin
			otf_en_i = (j < 4);
			fixed_bc4_i = (j == 4);
			interleave_i = j[1];
			ap = (j == 4);
			a12 = j[0] | ap;
			ch = ap | !j[0];
			len = ch ? 4 : 8;
			go(CMD_RD, 1'b1, 3'h3, {3'h0, a12, 1'b0, ap, 10'h0f6});
			for (int b = 0; b < len; b++) begin
				go((b == 1) ? CMD_RD : CMD_NOP, 1'b1, 3'h3, 16'h0002);
				check("col", rd_col_o, col_at(10'h0f6, b, j[1], ch));
				if (b == 0) begin
					check("row", rd_row_o, 32'h1234);
					check("chop", rd_chop_o, ch);
					check("ap", rd_ap_o, ap);
				end
				if (b == 2) check("illegal", illegal_o, 32'h1);
			end
			go(CMD_NOP);
			check("busy", rd_busy_o, 32'h0);
			check("banks", bank_open_o, ap ? 32'h00 : 32'h08);
		end
		// Active power-down, command ignored while low
		go(CMD_ACT, 1'b1, 3'h3, 16'h0042);
		go(CMD_NOP, 1'b0);
		go(CMD_REF, 1'b0);
		check("pstate", pstate_o, 32'h08);
		go(CMD_ACT, 1'b0);
		check("pd", pd_o, 32'h1);
		go(CMD_NOP);
		go(CMD_NOP);
		check("pstate", pstate_o, 32'h02);
		go(CMD_PRE, 1'b1, 3'h3, 16'h0000);
		nops(2);
		go(CMD_DES, 1'b0);
		go(CMD_DES, 1'b0);
		check("pstate", pstate_o, 32'h04);
		go(CMD_DES, 1'b0);
		go(CMD_DES);
		go(CMD_NOP);
		check("pstate", pstate_o, 32'h01);
		// Refresh window refuses activation
		go(CMD_REF);
		go(CMD_ACT);
		check("refreshing", refreshing_o, 32'h1);
		go(CMD_NOP);
		check("illegal", illegal_o, 32'h1);
		for (len = 0; len < 100 && refreshing_o !== 1'b0; len++) go(CMD_NOP);
		if (len == 100) begin
			n_mismatch++;
			tally_and_finish();
		end
		go(CMD_REF, 1'b0);
		go(CMD_DES, 1'b0);
		check("pstate", pstate_o, 32'h10);
		go(CMD_NOP, 1'b0);
		go(CMD_NOP);
		go(CMD_NOP);
		check("pstate", pstate_o, 32'h01);
		check("self_ref", self_ref_o, 32'h0);
		tally_and_finish();
	end
endmodule : sdck_cmd_tb_top

bind sdck_cmd sdck_cmd_props u_props (.mclk_i, .resetn_i, .cke_i, .cs_n_i, .ras_n_i, .cas_n_i,
	.we_n_i, .ba_i, .addr_i, .otf_en_i, .cal_code_i, .pstate_o, .pd_o, .self_ref_o,
	.refreshing_o, .illegal_o, .rd_busy_o, .rd_ap_o, .cal_busy_o, .cal_update_o, .bank_open_o,
	.rd_bank_o, .rd_col_o, .ron_code_o, .odt_code_o);
